//--- bench/acr_host.sv
`timescale 1ns/1ps
`default_nettype none

module acr_host (
  // Clock
  input  wire logic          i_clk_sys,
  // Requests towards the device
  output logic               o_ctrl_wr,
  output acr_pkg::acr_ctrl_t o_ctrl,
  output logic               o_trim_wr,
  output logic [15:0]        o_trim_wdata,
  output logic               o_trim_rd,
  output logic               conversion_start_n,
  // Answers from the device
  input  wire logic [15:0]   i_trim_rdata,
  input  wire logic          i_trim_rvalid
);
  // ==========================================================
  // Idle levels
  // ==========================================================
  initial begin
    o_ctrl_wr = 1'b0;
    o_ctrl = '0;
    o_trim_wr = 1'b0;
    o_trim_wdata = '0;
    o_trim_rd = 1'b0;
    conversion_start_n = 1'b1;
  end

  // ==========================================================
  // Bus cycles
  // ==========================================================
  // Group select always precedes trim traffic; reads also pick source 10
  task automatic ctrl(input logic [1:0] grp, input logic [1:0] src, input logic st);
    @(posedge i_clk_sys);
    o_ctrl_wr <= 1'b1;
    o_ctrl <= acr_pkg::acr_ctrl_t'({grp, src, st});
    @(posedge i_clk_sys);
    o_ctrl_wr <= 1'b0;
    o_ctrl <= acr_pkg::acr_ctrl_t'(~{grp, src, st});
  endtask

  task automatic twr(input logic [15:0] d);
    @(posedge i_clk_sys);
    o_trim_wr <= 1'b1;
    o_trim_wdata <= d;
    @(posedge i_clk_sys);
    o_trim_wr <= 1'b0;
    o_trim_wdata <= ~d;
  endtask

  // Reads are issued only between conversions; a control write may restart a sequence before its end
  task automatic trd(output logic v, output logic [15:0] d);
    @(posedge i_clk_sys);
    o_trim_rd <= 1'b1;
    @(posedge i_clk_sys);
    o_trim_rd <= 1'b0;
    #1;
    v = i_trim_rvalid;
    d = i_trim_rdata;
  endtask

  // Next start only after conversion plus two acquisition periods
  // Low phase spans over two master clock periods so the synchroniser sees it
  task automatic pin_start();
    @(posedge i_clk_sys);
    conversion_start_n <= 1'b0;
    repeat (30) @(posedge i_clk_sys);
    conversion_start_n <= 1'b1;
  endtask
endmodule

`default_nettype wire

//--- bench/adc_cal_regs_and_conversion_start_test.sv
`timescale 1ns/1ps
`default_nettype none

module adc_cal_regs_and_conversion_start_test;
  logic clk_sys = 1'b0;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ctrl_wr, trim_wr, trim_rd, rvalid, start_n, busy, sw_start;
  logic [15:0] wdata, rdata, status;
  acr_pkg::acr_ctrl_t ctrl;
  logic [15:0] exp_w [10];
  int failures = 0;
  int samples_checked = 0;

  always #5 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #62.5 mclk = ~mclk;
  end

  acr_core i_dut (.i_clk_sys(clk_sys), .i_rst(rst), .master_clock_in(mclk), .i_ctrl_wr(ctrl_wr),
    .i_ctrl(ctrl), .i_trim_wr(trim_wr), .i_trim_wdata(wdata), .i_trim_rd(trim_rd), .o_trim_rdata(rdata),
    .o_trim_rvalid(rvalid), .conversion_start_n(start_n), .o_busy(busy), .o_status(status),
    .o_sw_start(sw_start));
  acr_host i_host (.i_clk_sys(clk_sys), .o_ctrl_wr(ctrl_wr), .o_ctrl(ctrl), .o_trim_wr(trim_wr),
    .o_trim_wdata(wdata), .o_trim_rd(trim_rd), .conversion_start_n(start_n), .i_trim_rdata(rdata),
    .i_trim_rvalid(rvalid));

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic rd_exp(input string what, input logic [15:0] exp);
    logic v;
    logic [15:0] d;
    i_host.trd(v, d);
    chk({what, " valid"}, 16'h0001, {15'h0, v});
    chk(what, exp, d);
  endtask

  task automatic rd_none();
    logic v;
    logic [15:0] d;
    i_host.trd(v, d);
    chk("ignored read", 16'h0000, {15'h0, v});
  endtask

  task automatic wait_busy(input logic lvl, output realtime t);
    int n;
    n = 0;
    while (busy !== lvl && n < 5000) begin
      #1;
      n++;
    end
    t = $realtime;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset_all();
    chk("status", 16'h0000, status);
    i_host.ctrl(2'h0, 2'h2, 1'b0);
    for (int i = 0; i < 10; i++) rd_exp("reset trim", (i < 2) ? 16'h2000 : 16'h0000);
    rd_none();
  endtask

  task automatic t_write_all();
    i_host.ctrl(2'h0, 2'h0, 1'b0);
    for (int i = 0; i < 10; i++) begin
      i_host.twr(16'hc000 | 16'(i * 16'h0123));
      exp_w[i] = 16'(i * 16'h0123) & 16'h3fff;
    end
    i_host.twr(16'h3333);
    i_host.ctrl(2'h0, 2'h2, 1'b0);
    for (int i = 0; i < 10; i++) rd_exp("trim word", exp_w[i]);
  endtask

  task automatic t_groups();
    i_host.ctrl(2'h2, 2'h0, 1'b0);
    i_host.twr(16'h1555);
    i_host.ctrl(2'h3, 2'h0, 1'b0);
    i_host.twr(16'h0aaa);
    i_host.ctrl(2'h2, 2'h2, 1'b0);
    rd_exp("offset only", 16'h1555);
    rd_none();
    i_host.ctrl(2'h3, 2'h2, 1'b0);
    rd_exp("gain only", 16'h0aaa);
    i_host.ctrl(2'h1, 2'h2, 1'b0);
    rd_exp("pair gain", 16'h0aaa);
    rd_exp("pair offset", 16'h1555);
    rd_none();
    i_host.ctrl(2'h1, 2'h0, 1'b0);
    rd_none();
  endtask

  task automatic t_abort();
    i_host.ctrl(2'h0, 2'h2, 1'b0);
    rd_exp("abort gain", 16'h0aaa);
    rd_exp("abort offset", 16'h1555);
    i_host.ctrl(2'h0, 2'h2, 1'b0);
    rd_exp("after abort", 16'h0aaa);
  endtask

  task automatic t_pin_start();
    realtime t0, t1, t2;
    i_host.pin_start();
    t0 = $realtime;
    wait_busy(1'b1, t1);
    chk("start delay", 16'h0001, {15'h0, (t1 - t0) < 400.0});
    #100;
    chk("status busy", 16'h4000, status);
    wait_busy(1'b0, t2);
    chk("busy span", 16'h0001, {15'h0, (t2 - t1) > 2060.0 && (t2 - t1) < 2065.0});
    #100;
    chk("status idle", 16'h0000, status);
  endtask

  task automatic t_sw_start();
    realtime t;
    for (int k = 0; k < 2; k++) begin
      i_host.ctrl(2'h0, 2'h0, 1'b1);
      #1;
      chk("sw start set", 16'h0001, {15'h0, sw_start});
      wait_busy(1'b1, t);
      chk("sw busy", 16'h0001, {15'h0, busy});
      wait_busy(1'b0, t);
      #80;
      chk("sw start clear", 16'h0000, {15'h0, sw_start});
      #250;
    end
  endtask

  // ==========================================================
  // Sequence and watchdog
  // ==========================================================
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_reset_all();
    t_write_all();
    t_groups();
    t_abort();
    t_pin_start();
    t_sw_start();
    give_verdict();
  end

  initial begin
    #100000;
    failures++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule

`default_nettype wire

//--- rtl/acr_core.sv
`timescale 1ns/1ps
`default_nettype none

module acr_core (
  // System clock and reset
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rst,
  // Master clock for the conversion engine
  input  wire logic                     master_clock_in,
  // Control word writes
  input  wire logic                     i_ctrl_wr,
  input  wire acr_pkg::acr_ctrl_t       i_ctrl,
  // Trim word access
  input  wire logic                     i_trim_wr,
  input  wire logic [15:0]              i_trim_wdata,
  input  wire logic                     i_trim_rd,
  output logic      [15:0]              o_trim_rdata,
  output logic                          o_trim_rvalid,
  // Start pin and status
  input  wire logic                     conversion_start_n,
  output logic                          o_busy,
  output logic      [15:0]              o_status,
  output logic                          o_sw_start
);

  // ==========================================================
  // Trim addressing
  // ==========================================================
  function automatic logic [3:0] seq_len(input logic [1:0] grp);
    case (grp)
      acr_pkg::GRP_ALL:      seq_len = acr_pkg::LEN_ALL;
      acr_pkg::GRP_GAIN_OFS: seq_len = acr_pkg::LEN_GAIN_OFS;
      default:               seq_len = acr_pkg::LEN_SINGLE;
    endcase
  endfunction

  function automatic logic [3:0] step_to_idx(input logic [1:0] grp, input logic [3:0] step);
    if (grp == acr_pkg::GRP_OFFSET) begin
      step_to_idx = acr_pkg::IDX_OFFSET;
    end else if (grp == acr_pkg::GRP_GAIN) begin
      step_to_idx = acr_pkg::IDX_GAIN;
    end else begin
      step_to_idx = step;
    end
  endfunction

  logic [13:0] trim_mem [acr_pkg::TRIM_COUNT];
  logic [1:0]  grp;
  logic        rd_armed;
  logic        active;
  logic [3:0]  step;
  logic [3:0]  cur_idx;
  logic        access;
  logic        last_step;

  assign cur_idx   = step_to_idx(grp, step);
  assign access    = active && (i_trim_wr || (i_trim_rd && rd_armed));
  assign last_step = (step == seq_len(grp) - 4'h1);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      grp      <= acr_pkg::GRP_ALL;
      rd_armed <= 1'b0;
    end else if (i_ctrl_wr) begin
      grp      <= {i_ctrl.trim_group_sel_hi, i_ctrl.trim_group_sel_lo};
      rd_armed <= ({i_ctrl.read_source_sel_hi, i_ctrl.read_source_sel_lo} == acr_pkg::RDSRC_TRIM);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      step   <= 4'h0;
      active <= 1'b0;
    end else if (i_ctrl_wr) begin
      step   <= 4'h0;
      active <= 1'b1;
    end else if (access) begin
      if (last_step) begin
        step   <= 4'h0;
        active <= 1'b0;
      end else begin
        step <= step + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      for (int i = 0; i < acr_pkg::TRIM_COUNT; i++) begin
        trim_mem[i] <= acr_pkg::DAC_RESET;
      end
      trim_mem[acr_pkg::IDX_GAIN]   <= acr_pkg::GAIN_RESET;
      trim_mem[acr_pkg::IDX_OFFSET] <= acr_pkg::OFFSET_RESET;
    end else if (access && i_trim_wr) begin
      trim_mem[cur_idx] <= i_trim_wdata[13:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_trim_rdata  <= 16'h0000;
      o_trim_rvalid <= 1'b0;
    end else begin
      o_trim_rvalid <= access && !i_trim_wr && i_trim_rd;
      if (access && !i_trim_wr) begin
        o_trim_rdata <= {acr_pkg::LEAD_ZEROS, trim_mem[cur_idx]};
      end
    end
  end

  // ==========================================================
  // Reset and start crossing into the master clock domain
  // ==========================================================
  logic       lrst_m;
  logic       lrst;
  logic       sw_tgl;
  logic [2:0] sw_sync;
  logic [2:0] pin_sync;
  logic       tgl_a;
  logic       tgl_b;
  logic [4:0] conv_cnt;
  logic       conv_busy;
  logic       start_req;

  always_ff @(negedge master_clock_in) begin
    lrst_m   <= i_rst;
    lrst     <= lrst_m;
    sw_sync  <= {sw_sync[1:0], sw_tgl};
    pin_sync <= {pin_sync[1:0], conversion_start_n};
  end

  // Pin rising edge or software toggle; a start that misses the edge setup
  // waits one more master clock period through the synchroniser.
  assign start_req = (pin_sync[1] && !pin_sync[2]) || (sw_sync[1] ^ sw_sync[2]);
  // Only one of the two toggles moves at a time, so busy cannot glitch
  assign conv_busy = tgl_a ^ tgl_b;

  always_ff @(negedge master_clock_in) begin
    if (lrst) begin
      tgl_a    <= 1'b0;
      conv_cnt <= 5'h00;
    end else if (!conv_busy && start_req) begin
      tgl_a    <= ~tgl_a;
      conv_cnt <= 5'h00;
    end else if (conv_busy && conv_cnt != acr_pkg::CONV_FULL_PER) begin
      conv_cnt <= conv_cnt + 5'h01;
    end
  end

  // Half period after the sixteenth falling edge ends the conversion
  always_ff @(posedge master_clock_in) begin
    if (lrst) begin
      tgl_b <= 1'b0;
    end else if (conv_busy && conv_cnt == acr_pkg::CONV_FULL_PER) begin
      tgl_b <= ~tgl_b;
    end
  end

  assign o_busy = conv_busy;

  // ==========================================================
  // Software start bit and status in the system domain
  // ==========================================================
  logic busy_m;
  logic busy_s;
  logic busy_d;
  logic busy_fall;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      busy_m <= 1'b0;
      busy_s <= 1'b0;
      busy_d <= 1'b0;
    end else begin
      busy_m <= conv_busy;
      busy_s <= busy_m;
      busy_d <= busy_s;
    end
  end

  assign busy_fall = busy_d && !busy_s;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_sw_start <= 1'b0;
      sw_tgl     <= 1'b0;
    end else if (i_ctrl_wr && i_ctrl.conv_start) begin
      o_sw_start <= 1'b1;
      sw_tgl     <= ~sw_tgl;
    end else if (busy_fall) begin
      o_sw_start <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_status <= acr_pkg::STAT_RESET;
    end else begin
      o_status <= acr_pkg::STAT_RESET;
      o_status[acr_pkg::STAT_BUSY_BIT] <= busy_s;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_ctrl_write;
    i_ctrl_wr;
  endsequence

  sequence s_armed_first;
    active && step == 4'h0;
  endsequence

  chk_ptr_reset_ctrl: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_ctrl_write |=> s_armed_first)
    else $error("pointer not reset by control write");

  chk_first_offset: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ctrl_wr && {i_ctrl.trim_group_sel_hi, i_ctrl.trim_group_sel_lo} == acr_pkg::GRP_OFFSET)
      |=> cur_idx == acr_pkg::IDX_OFFSET)
    else $error("offset-only group does not start at offset");

  chk_ptr_advance: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (access && !i_ctrl_wr && !last_step) |=> step == $past(step) + 4'h1)
    else $error("pointer did not advance");

  chk_seq_complete: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (access && !i_ctrl_wr && last_step) |=> !active && step == 4'h0)
    else $error("sequence did not close at its end");

  chk_lead_zeros: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_trim_rvalid |-> o_trim_rdata[15:14] == acr_pkg::LEAD_ZEROS)
    else $error("trim read missing leading zeros");

  chk_ignore_idle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (!active && i_trim_wr) |=> trim_mem[$past(cur_idx)] == $past(trim_mem[cur_idx]))
    else $error("idle trim write changed storage");

  chk_swstart_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (busy_fall && !i_ctrl_wr) |=> !o_sw_start)
    else $error("software start not cleared by busy fall");

  chk_status_busy: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ##1 o_status[acr_pkg::STAT_BUSY_BIT] == $past(busy_s))
    else $error("status busy bit wrong");

  chk_conv_length: assert property (@(negedge master_clock_in) disable iff (lrst)
    $rose(conv_busy) |-> conv_busy throughout (##15 conv_cnt == 5'h0f))
    else $error("conversion shorter than sixteen periods");

  chk_busy_end: assert property (@(posedge master_clock_in) disable iff (lrst)
    (conv_busy && conv_cnt == acr_pkg::CONV_FULL_PER) |=> !conv_busy)
    else $error("busy not dropped after sixteen and a half periods");

  chk_first_gain: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ctrl_wr && {i_ctrl.trim_group_sel_hi, i_ctrl.trim_group_sel_lo} != acr_pkg::GRP_OFFSET)
      |=> cur_idx == acr_pkg::IDX_GAIN)
    else $error("group does not start at gain");

  chk_trim_store: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (access && i_trim_wr) |=> trim_mem[$past(cur_idx)] == $past(i_trim_wdata[13:0]))
    else $error("trim write did not land at the pointer");

  chk_read_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_trim_rd && !rd_armed) |=> !o_trim_rvalid)
    else $error("trim read answered without trim read source");

  chk_swstart_set: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ctrl_wr && i_ctrl.conv_start) |=> o_sw_start)
    else $error("software start bit not set by control write");

  chk_start_busy: assert property (@(negedge master_clock_in) disable iff (lrst)
    (!conv_busy && start_req) |=> conv_busy)
    else $error("start request did not raise busy");

endmodule

`default_nettype wire

//--- rtl/acr_pkg.sv
package acr_pkg;

  // ==========================================================
  // Trim storage layout
  // ==========================================================
  localparam int unsigned TRIM_COUNT      = 10;
  localparam int unsigned TRIM_DATA_W     = 14;
  localparam int unsigned WORD_W          = 16;
  localparam logic [3:0]  IDX_GAIN        = 4'h0;
  localparam logic [3:0]  IDX_OFFSET      = 4'h1;
  localparam logic [3:0]  IDX_DAC0        = 4'h2;
  localparam logic [3:0]  IDX_LAST        = 4'h9;
  localparam logic [13:0] OFFSET_RESET    = 14'h2000;
  localparam logic [13:0] GAIN_RESET      = 14'h2000;
  localparam logic [13:0] DAC_RESET       = 14'h0000;
  localparam logic [1:0]  LEAD_ZEROS      = 2'h0;

  // ==========================================================
  // Group select codes and sequence lengths
  // ==========================================================
  localparam logic [1:0]  GRP_ALL         = 2'h0;
  localparam logic [1:0]  GRP_GAIN_OFS    = 2'h1;
  localparam logic [1:0]  GRP_OFFSET      = 2'h2;
  localparam logic [1:0]  GRP_GAIN        = 2'h3;
  localparam logic [3:0]  LEN_ALL         = 4'ha;
  localparam logic [3:0]  LEN_GAIN_OFS    = 4'h2;
  localparam logic [3:0]  LEN_SINGLE      = 4'h1;
  localparam logic [1:0]  RDSRC_TRIM      = 2'h2;

  // ==========================================================
  // Status word
  // ==========================================================
  localparam int unsigned STAT_BUSY_BIT   = 14;
  localparam logic [15:0] STAT_RESET      = 16'h0000;

  // ==========================================================
  // Conversion timing in master clock periods, setup in ns and system clock cycles
  // ==========================================================
  localparam logic [4:0]  CONV_FULL_PER   = 5'h10;
  localparam int unsigned SETUP_NS        = 10;
  localparam int unsigned SYS_PERIOD_NS   = 10;
  localparam int unsigned SETUP_CYC       = (SETUP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  typedef struct packed {
    logic trim_group_sel_hi;
    logic trim_group_sel_lo;
    logic read_source_sel_hi;
    logic read_source_sel_lo;
    logic conv_start;
  } acr_ctrl_t;

endpackage
